// File: core/energy_pulse_output_timing.v
// Pulse timing for the two counter-drive outputs and the calibration output.
// Assumes signed power samples arrive on ref_clk from the multiplier path,
// while the master-clear and frequency-select inputs come straight from pins.
//
// Summary of operation
// R1 - Counter pulses low for 984376 clock periods.
// R2 - Fast counter pulses: low width is half period.
// R3 - Calibration pulses low for 322160 clock periods.
// R4 - Fast calibration pulses: width is half period.
// R5 - Select code 0,1,1 fixes calibration width 64.
// R6 - Counter outputs alternate, half period apart.
// R7 - Counter falling edges at least four periods apart.
// R8 - Host ends entry code within eight periods.
// R9 - Host starts entry code after one period.
// R10 - Low master clear resets all registers; the pin synchronisers are reset only by rst_n.
// R11 - Outside serial mode, pins are frequency selects.
// R12 - Periods follow averaged power times frequency constants.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_consts.vh"

module energy_pulse_output_timing #(
  parameter [31:0] COUNTER_WIDTH     = `COUNTER_PULSE_WIDTH_CYCLES,
  parameter [31:0] CALIBRATION_WIDTH = `CALIBRATION_PULSE_WIDTH_CYCLES
) (
  input  wire        ref_clk,             // Master clock, 125 MHz.
  input  wire        rst_n,               // Synchronous reset, active low.
  input  wire        master_clear_n,      // Master clear pin, active low.
  input  wire        freq_select_top,     // Frequency select pin, top bit.
  input  wire        freq_select_mid,     // Frequency select pin, middle bit.
  input  wire        freq_select_low,     // Frequency select pin, low bit.
  input  wire        serialMode,          // Pins serve the serial port.
  input  wire        powerValid,          // Power sample strobe.
  input  wire [19:0] powerSample,         // Averaged power, two's complement.
  output wire        counter_drive_a_n,   // Counter drive A, active low.
  output wire        counter_drive_b_n,   // Counter drive B, active low.
  output wire        calibration_pulse_out_n, // Calibration output, active low.
  output reg         negative_power_flag  // Power is negative.
);

  // Pin synchronisers: the first stage feeds only the second.
  reg        clearMeta_q;
  reg        clearSync_q;
  reg  [2:0] selectMeta_q;
  reg  [2:0] selectSync_q;
  reg  [2:0] selectHeld_q;

  reg  [31:0] ctrAcc_q;
  reg  [31:0] calAcc_q;
  reg         ctrPending_q;
  reg  [2:0]  sepCnt_q;
  reg         driveSel_q;
  reg         fireA_q;
  reg         fireB_q;
  reg         fireCal_q;
  reg  [31:0] ctrAcc_d;
  reg  [31:0] calAcc_d;
  reg         ctrPending_d;
  reg  [2:0]  sepCnt_d;
  reg         driveSel_d;
  reg         fireA_d;
  reg         fireB_d;

  wire        clear;
  wire [19:0] powerMag;
  wire [31:0] magWide;
  wire [31:0] ctrThresh;
  wire [31:0] calThresh;
  wire [2:0]  calShift;
  wire [31:0] ctrSum;
  wire [31:0] calSum;
  wire        ctrReach;
  wire        calReach;
  wire        sepOk;
  wire        fixedCal;

  // The pin reset is synchronised, so clear follows the pin two clocks late; a short glitch still clears if a clock edge catches it.
  assign clear = !rst_n || !clearSync_q; // R10

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clearMeta_q  <= 1'b0;
      clearSync_q  <= 1'b0;
      selectMeta_q <= 3'h0;
      selectSync_q <= 3'h0;
    end else begin
      clearMeta_q  <= master_clear_n;
      clearSync_q  <= clearMeta_q;
      selectMeta_q <= {freq_select_top, freq_select_mid, freq_select_low};
      selectSync_q <= selectMeta_q;
    end
  end

  // While the pins carry serial traffic the last select code is kept.
  // On leaving serial mode the synchroniser still holds two cycles of pin traffic,
  // so the code can flick briefly; samples should wait a few cycles after the exit.
  always @(posedge ref_clk) begin
    if (clear) begin
      selectHeld_q <= 3'h0;
    end else if (!serialMode) begin
      selectHeld_q <= selectSync_q; // R11
    end
  end

  // The fixed width ignores the measured period, so a calibration rig sees the
  // same short pulse at any rate.
  assign fixedCal = (selectHeld_q == `CAL_FIXED_SELECT_CODE);

  // Energy thresholds stand in for the frequency constants of the transfer.
  assign powerMag  = powerSample[19] ? (~powerSample + 20'h00001) : powerSample;
  assign magWide   = {12'h000, powerMag};
  assign ctrThresh = `COUNTER_BASE_THRESHOLD << selectHeld_q[1:0]; // R12
  assign calShift  = selectHeld_q[2] ? `CAL_SHIFT_FAST : `CAL_SHIFT_SLOW;
  assign calThresh = ctrThresh >> calShift; // R12
  assign ctrSum    = ctrAcc_q + magWide;
  assign calSum    = calAcc_q + magWide;
  assign ctrReach  = powerValid && (ctrSum >= ctrThresh);
  assign calReach  = powerValid && (calSum >= calThresh);
  assign sepOk     = (sepCnt_q >= `COUNTER_MIN_SEPARATION_CYCLES - 3'h1);

  // Only one threshold comes off per sample, so the excess of a large sample
  // carries into later events instead of being dropped.
  always @* begin
    ctrAcc_d = ctrAcc_q;
    calAcc_d = calAcc_q;
    if (powerValid) begin
      ctrAcc_d = ctrReach ? ctrSum - ctrThresh : ctrSum; // R12
      calAcc_d = calReach ? calSum - calThresh : calSum; // R12
    end
  end

  always @(posedge ref_clk) begin
    if (clear) begin
      ctrAcc_q            <= 32'h00000000;
      calAcc_q            <= 32'h00000000;
      negative_power_flag <= 1'b0;
    end else begin
      ctrAcc_q <= ctrAcc_d;
      calAcc_q <= calAcc_d;
      if (powerValid) begin
        negative_power_flag <= powerSample[19];
      end
    end
  end

  // An event waits until the previous falling edge is far enough behind.
  // A burst of events faster than the spacing folds into one pending pulse.
  // The spacing counter stops at its top value, so a long idle gap never
  // wraps round into a false short one.
  always @* begin
    ctrPending_d = ctrPending_q;
    sepCnt_d     = sepCnt_q;
    driveSel_d   = driveSel_q;
    fireA_d      = 1'b0;
    fireB_d      = 1'b0;
    if ((ctrPending_q || ctrReach) && sepOk) begin
      ctrPending_d = 1'b0;
      sepCnt_d     = 3'h0; // R7
      driveSel_d   = !driveSel_q; // R6
      fireA_d      = !driveSel_q; // R6
      fireB_d      = driveSel_q; // R6
    end else begin
      if (ctrReach) begin
        ctrPending_d = 1'b1;
      end
      if (sepCnt_q != 3'h7) begin
        sepCnt_d = sepCnt_q + 3'h1; // R7
      end
    end
  end

  always @(posedge ref_clk) begin
    if (clear) begin
      ctrPending_q <= 1'b0;
      sepCnt_q     <= 3'h7;
      driveSel_q   <= 1'b0;
      fireA_q      <= 1'b0;
      fireB_q      <= 1'b0;
      fireCal_q    <= 1'b0;
    end else begin
      ctrPending_q <= ctrPending_d;
      sepCnt_q     <= sepCnt_d;
      driveSel_q   <= driveSel_d;
      fireA_q      <= fireA_d;
      fireB_q      <= fireB_d;
      fireCal_q    <= calReach;
    end
  end

  // Each output measures its own period, so alternation puts B half a period after A.
  pulse_channel #(
    .FULL_WIDTH  (COUNTER_WIDTH),
    .FIXED_WIDTH (`CAL_FIXED_WIDTH_CYCLES)
  ) driveA (
    .ref_clk    (ref_clk),
    .clear      (clear),
    .fire       (fireA_q), // R1 R2
    .fixedMode  (1'b0),
    .pulseOut_n (counter_drive_a_n)
  );

  pulse_channel #(
    .FULL_WIDTH  (COUNTER_WIDTH),
    .FIXED_WIDTH (`CAL_FIXED_WIDTH_CYCLES)
  ) driveB (
    .ref_clk    (ref_clk),
    .clear      (clear),
    .fire       (fireB_q), // R1 R2
    .fixedMode  (1'b0),
    .pulseOut_n (counter_drive_b_n)
  );

  pulse_channel #(
    .FULL_WIDTH  (CALIBRATION_WIDTH),
    .FIXED_WIDTH (`CAL_FIXED_WIDTH_CYCLES)
  ) calOut (
    .ref_clk    (ref_clk),
    .clear      (clear),
    .fire       (fireCal_q), // R3 R4
    .fixedMode  (fixedCal), // R5
    .pulseOut_n (calibration_pulse_out_n)
  );

endmodule

`default_nettype wire

// File: core/pulse_consts.vh
// Constants for the active-power pulse output timing block.
// Assumes all counts are in master-clock periods, which equal ref_clk cycles.
`ifndef PULSE_CONSTS_VH
`define PULSE_CONSTS_VH

// Low time of each counter-drive pulse, in master-clock periods.
`define COUNTER_PULSE_WIDTH_CYCLES     32'h000F0538
// Low time of each calibration pulse, in master-clock periods.
`define CALIBRATION_PULSE_WIDTH_CYCLES 32'h0004EA70
// Fixed calibration pulse width in the short-pulse select code.
`define CAL_FIXED_WIDTH_CYCLES         32'h00000040
// Select code {top, mid, low} that chooses the fixed calibration pulse.
`define CAL_FIXED_SELECT_CODE          3'h3
// Least spacing between the falling edges of the two counter outputs.
`define COUNTER_MIN_SEPARATION_CYCLES  3'h4
// Host-side serial entry code window limits, in master-clock periods.
`define ENTRY_CODE_WINDOW_CYCLES       4'h8
`define ENTRY_CODE_WINDOW_START_CYCLES 4'h1
// Energy per counter event at the highest frequency constant.
`define COUNTER_BASE_THRESHOLD         32'h00100000
// Calibration events come this many doublings faster than counter events.
`define CAL_SHIFT_SLOW                 3'h5
`define CAL_SHIFT_FAST                 3'h7

`endif

// File: core/pulse_channel.v
// One active-low pulse output with a width that shrinks to half the period.
// Assumes fire is a one-cycle pulse on ref_clk and clear is synchronous.
`timescale 1ns/100ps
`default_nettype none

module pulse_channel #(
  parameter [31:0] FULL_WIDTH  = 32'h00000040,
  parameter [31:0] FIXED_WIDTH = 32'h00000040
) (
  input  wire        ref_clk,    // Master clock.
  input  wire        clear,      // Synchronous clear, active high.
  input  wire        fire,       // Start a pulse.
  input  wire        fixedMode,  // Use the fixed width.
  output reg         pulseOut_n  // Pulse output, active low.
);

  reg  [31:0] periodCnt_q;
  reg  [31:0] widthLeft_q;
  wire [31:0] fullTwice;
  wire [31:0] chosenWidth;

  assign fullTwice = {FULL_WIDTH[30:0], 1'b0};

  // Outside fixed mode the last measured period decides the width; a first pulse uses full width.
  assign chosenWidth = fixedMode ? FIXED_WIDTH : // R5
                       (periodCnt_q < fullTwice) ? {1'b0, periodCnt_q[31:1]} : // R2 R4
                       FULL_WIDTH; // R1 R3

  always @(posedge ref_clk) begin
    if (clear) begin
      periodCnt_q <= 32'hFFFFFFFF;
      widthLeft_q <= 32'h00000000;
      pulseOut_n  <= 1'b1;
    end else begin
      if (fire) begin
        periodCnt_q <= 32'h00000001;
      end else if (periodCnt_q != 32'hFFFFFFFF) begin
        periodCnt_q <= periodCnt_q + 32'h00000001;
      end
      if (fire && chosenWidth != 32'h00000000) begin
        widthLeft_q <= chosenWidth - 32'h00000001;
        pulseOut_n  <= 1'b0;
      end else if (widthLeft_q != 32'h00000000) begin
        widthLeft_q <= widthLeft_q - 32'h00000001;
      end else begin
        pulseOut_n  <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/energy_pulse_output_timing_monitor.sv
// Assertions on the pulse timing block ports.
// Assumes one clock; bound to the top module below.
`timescale 1ns/100ps
`default_nettype none
module energy_pulse_output_timing_monitor #(
  parameter [31:0] COUNTER_WIDTH     = 32'hF0538,
  parameter [31:0] CALIBRATION_WIDTH = 32'h4EA70
) (
  input wire logic        ref_clk,                 // Clock.
  input wire logic        rst_n,                   // Reset.
  input wire logic        master_clear_n,          // Clear.
  input wire logic        freq_select_top,         // Select.
  input wire logic        freq_select_mid,         // Select.
  input wire logic        freq_select_low,         // Select.
  input wire logic        serialMode,              // Mode.
  input wire logic        powerValid,              // Strobe.
  input wire logic [19:0] powerSample,             // Sample.
  input wire logic        counter_drive_a_n,       // Out A.
  input wire logic        counter_drive_b_n,       // Out B.
  input wire logic        calibration_pulse_out_n, // Cal.
  input wire logic        negative_power_flag      // Sign.
);
  logic       aLast_q;
  logic [2:0] upCnt_q;
  // The order tracker restarts on either clear so that A is due first again.
  always @(posedge ref_clk) begin
    if (!rst_n || !master_clear_n) begin
      aLast_q <= 1'b0;
      upCnt_q <= 3'h0;
    end else begin
      if ($fell(counter_drive_a_n)) aLast_q <= 1'b1;
      else if ($fell(counter_drive_b_n)) aLast_q <= 1'b0;
      if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence quietB; !$fell(counter_drive_b_n) [*4]; endsequence
  sequence quietA; !$fell(counter_drive_a_n) [*4]; endsequence
  a_gap_a_b: assert property ($fell(counter_drive_a_n) |-> quietB)
    else $error("B fell too soon after A");
  a_gap_b_a: assert property ($fell(counter_drive_b_n) |-> quietA)
    else $error("A fell too soon after B");
  a_order_a: assert property ($fell(counter_drive_a_n) |-> !aLast_q)
    else $error("A fell twice in a row");
  a_order_b: assert property ($fell(counter_drive_b_n) |-> aLast_q)
    else $error("B fell out of turn");
  a_cal_cause: assert property ($fell(calibration_pulse_out_n) |-> $past(powerValid, 2))
    else $error("cal fell without a sample");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> counter_drive_a_n &&
    counter_drive_b_n && calibration_pulse_out_n && !negative_power_flag)
    else $error("outputs not idle in reset");
  a_clear_idle: assert property (!master_clear_n [*4] |-> counter_drive_a_n &&
    counter_drive_b_n && calibration_pulse_out_n)
    else $error("outputs not idle in clear");
  a_sign_flag: assert property (powerValid && upCnt_q == 3'h7 |=>
    negative_power_flag == $past(powerSample[19]))
    else $error("flag does not follow sign");
endmodule
bind energy_pulse_output_timing energy_pulse_output_timing_monitor #(
  .COUNTER_WIDTH(COUNTER_WIDTH), .CALIBRATION_WIDTH(CALIBRATION_WIDTH)) i_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
  .freq_select_top(freq_select_top), .freq_select_mid(freq_select_mid),
  .freq_select_low(freq_select_low), .serialMode(serialMode), .powerValid(powerValid),
  .powerSample(powerSample), .counter_drive_a_n(counter_drive_a_n),
  .counter_drive_b_n(counter_drive_b_n), .negative_power_flag(negative_power_flag),
  .calibration_pulse_out_n(calibration_pulse_out_n));
`default_nettype wire

// File: tb/counter_load_model.sv
// Load on the pulse outputs: a counter and a calibration meter.
// Assumes active-low pulses sampled on the master clock.
`timescale 1ns/100ps
`default_nettype none
module counter_load_model (
  input  wire logic ref_clk,  // Clock.
  input  wire logic driveA_n, // Line A.
  input  wire logic driveB_n, // Line B.
  input  wire logic calOut_n, // Cal line.
  output var  int   widthA,   // Last A width.
  output var  int   widthCal, // Last cal width.
  output var  int   fallA,    // Last A fall.
  output var  int   fallB     // Last B fall.
);
  int   cyc, runA, runC;
  logic prevA, prevB;
  always @(posedge ref_clk) begin
    cyc   <= cyc + 1;
    prevA <= driveA_n;
    prevB <= driveB_n;
    if (!driveA_n && prevA) fallA <= cyc + 1;
    if (!driveB_n && prevB) fallB <= cyc + 1;
    if (!driveA_n) runA <= runA + 1;
    else if (runA != 0) begin
      widthA <= runA;
      runA   <= 0;
    end
    if (!calOut_n) runC <= runC + 1;
    else if (runC != 0) begin
      widthCal <= runC;
      runC     <= 0;
    end
  end
endmodule
`default_nettype wire

// File: tb/energy_pulse_output_timing_tb.sv
// Self-checking bench for the pulse timing block.
// Assumes the load model reports widths and fall cycles.
`timescale 1ns/100ps
`default_nettype none
module energy_pulse_output_timing_tb;
  typedef struct packed {logic [2:0] s; logic [19:0] v; logic [31:0] w; logic n;} row_t;
  row_t rows[4] = '{'{3'h0, 20'h08000, 32'h28, 1'b0}, '{3'h3, 20'h40000, 32'h40, 1'b0},
                    '{3'h4, 20'hFE000, 32'h28, 1'b1}, '{3'h0, 20'hF8000, 32'h28, 1'b1}};
  logic        ref_clk, rst_n, master_clear_n, serialMode, powerValid;
  logic [2:0]  sel;
  logic [19:0] powerSample;
  wire logic   outA_n, outB_n, cal_n, negFlag;
  int          wA, wC, fA, fB, errTotal, checkCount, cyc;
  // Widths are shortened so a full run stays near a thousand cycles.
  energy_pulse_output_timing #(.COUNTER_WIDTH(32'h64), .CALIBRATION_WIDTH(32'h28)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .master_clear_n(master_clear_n),
    .freq_select_top(sel[2]), .freq_select_mid(sel[1]), .freq_select_low(sel[0]),
    .serialMode(serialMode), .powerValid(powerValid), .powerSample(powerSample),
    .counter_drive_a_n(outA_n), .counter_drive_b_n(outB_n),
    .calibration_pulse_out_n(cal_n), .negative_power_flag(negFlag));
  counter_load_model i_load (.ref_clk(ref_clk), .driveA_n(outA_n), .driveB_n(outB_n),
    .calOut_n(cal_n), .widthA(wA), .widthCal(wC), .fallA(fA), .fallB(fB));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task automatic give(input logic [19:0] v);
    powerSample = v;
    powerValid = 1'b1;
    tick(1);
    powerValid = 1'b0;
  endtask
  // Each pair of full-scale negative samples makes exactly one counter event;
  // the strobe stays up between pairs so it is never lowered and raised at once.
  task automatic ev(input int n);
    powerSample = 20'h80000;
    powerValid = 1'b1;
    tick(2 * n);
    powerValid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2999) begin
      errTotal++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    master_clear_n = 1'b1;
    serialMode = 1'b0;
    powerValid = 1'b0;
    sel = 3'h0;
    powerSample = 20'h00000;
    tick(6);
    rst_n = 1'b1;
    tick(4);
    foreach (rows[i]) begin
      sel = rows[i].s;
      tick(4);
      give(rows[i].v);
      tick(84);
      check("cal width", wC, rows[i].w);
      check("flag", {31'h0, negFlag}, {31'h0, rows[i].n});
    end
    give(20'h08000);
    tick(59);
    give(20'h08000);
    tick(40);
    check("cal half width", wC, 32'h1E);
    serialMode = 1'b1;
    tick(1);
    repeat (3) begin
      sel = 3'h3;
      tick(1);
      sel = 3'h1;
      tick(1);
    end
    sel = 3'h3;
    tick(73);
    give(20'h08000);
    tick(50);
    check("frozen select", wC, 32'h28);
    serialMode = 1'b0;
    sel = 3'h0;
    tick(4);
    give(20'h08000);
    tick(5);
    master_clear_n = 1'b0;
    tick(4);
    check("cleared outs", {28'h0, outA_n, outB_n, cal_n, negFlag}, 32'hE);
    master_clear_n = 1'b1;
    tick(6);
    ev(1);
    tick(78);
    ev(1);
    tick(40);
    check("A full width", wA, 32'h64);
    check("A to B fall", fB - fA, 32'h50);
    tick(38);
    ev(1);
    tick(78);
    ev(1);
    tick(60);
    check("A half width", wA, 32'h50);
    tick(200);
    ev(2);
    tick(20);
    check("fall spacing", {31'h0, fB - fA >= 4}, 32'h1);
    rst_n = 1'b0;
    tick(2);
    check("reset outs", {28'h0, outA_n, outB_n, cal_n, negFlag}, 32'hE);
    tally_and_finish();
  end
endmodule
`default_nettype wire
